// ==== hdl/prfs_regs.svh ====
// constants for the management field-semantics register bank
// assumes: included by bare name from the package and design modules
`ifndef PRFS_REGS_SVH
`define PRFS_REGS_SVH

`define PRFS_ADDR_W        5
`define PRFS_DATA_W        16
// register indices on the management address
`define PRFS_IDX_CTRL      5'h00
`define PRFS_IDX_STAT      5'h01
`define PRFS_IDX_EVT       5'h02
`define PRFS_IDX_SCRATCH   5'h03
`define PRFS_IDX_CFG       5'h04
`define PRFS_IDX_KEY       5'h05
// control register fields
`define PRFS_CTRL_RST_BIT  15
`define PRFS_CTRL_START_BIT 14
`define PRFS_CTRL_MODE_LSB 0
`define PRFS_CTRL_MODE_W   4
// status register fields
`define PRFS_STAT_LH_BIT   0
`define PRFS_STAT_LL_BIT   1
`define PRFS_STAT_BUSY_BIT 2
`define PRFS_STAT_ACT_LSB  4
// reset values
`define PRFS_CTRL_MODE_RST 4'h0
`define PRFS_CFG_RST       16'h1E00
`define PRFS_ZERO16        16'h0000
`define PRFS_ONE8          8'h01
// function run time for self-clearing start
`define PRFS_FUNC_NS       40
`define PRFS_CLK_NS        4
`define PRFS_SRST_NS       8

`endif

// ==== hdl/prfs_pkg.sv ====
// types shared by the field-semantics bank and its self-clearing timer
// assumes: constants come from prfs_regs.svh
`include "prfs_regs.svh"
package prfs_pkg;
  typedef logic [`PRFS_DATA_W-1:0] prfs_word_t;
  typedef logic [`PRFS_ADDR_W-1:0] prfs_addr_t;

  // one management access, valid for a single cycle
  typedef struct packed {
    logic       rd;
    logic       wr;
    prfs_addr_t addr;
    prfs_word_t wdata;
  } prfs_req_s;

  typedef struct packed {
    logic       valid;
    prfs_word_t rdata;
  } prfs_rsp_s;

  typedef enum logic [1:0] {
    PRFS_IDLE,
    PRFS_RUN,
    PRFS_DONE
  } prfs_run_e;
endpackage

// ==== hdl/prfs_sc_timer.sv ====
// self-clearing function timer: a one-cycle start runs a fixed-length job
// assumes: start is a one-cycle pulse from the bank; single clock domain
`timescale 1ns/1ps
`include "prfs_regs.svh"
module prfs_sc_timer #(
  parameter int RUN_CYC = 10
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // control
  input  wire logic             start,
  output      logic             busy,
  output      logic             done
);
  import prfs_pkg::*;

  // ===================================================================
  // state
  prfs_run_e         state_ff,
                     nxt_state;
  logic [15:0]       cnt_ff,
                     nxt_cnt;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      PRFS_IDLE: begin
        if (start) begin
          nxt_state = PRFS_RUN;
          nxt_cnt   = 16'(RUN_CYC - 1);
        end
      end
      PRFS_RUN: begin
        if (cnt_ff == 16'h0000) begin
          nxt_state = PRFS_DONE;
        end else begin
          nxt_cnt = cnt_ff - 16'h0001;
        end
      end
      PRFS_DONE: begin
        nxt_state = PRFS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= PRFS_IDLE;
      cnt_ff   <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  assign busy = (state_ff == PRFS_RUN);
  assign done = (state_ff == PRFS_DONE);
endmodule

// ==== hdl/prfs_bank.sv ====
// management register bank showing each field access type of the device
// assumes: one-cycle read/write requests from the management interface logic,
// synchronous to sys_clk; status conditions are synchronous levels
//
// Contract
// - latching-high sets on high, holds until read
// - latching-low clears on low, holds until read
// - immediate fields act as soon as written
// - reserved bits read back zero
// - read-clear field restarts from zero at each read, keeping an event of the read cycle
// - rw clear-on-read: writable, zero after reset/read
// - zero-at-reset field: read/write, reset clears
// - preset field loads nonzero default at reset
// - self-clearing start runs, clears when done
// - deferred field applies only at software reset
`timescale 1ns/1ps
`include "prfs_regs.svh"
module prfs_bank #(
  parameter int ACT_W = 8
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  // management access
  input  wire prfs_pkg::prfs_req_s  mgmt_req,
  output      prfs_pkg::prfs_rsp_s  mgmt_rsp,
  // status conditions from the transceiver core
  input  wire logic                 cond_high,
  input  wire logic                 cond_low,
  input  wire logic                 evt_pulse,
  // controls applied to the transceiver core
  output      logic [`PRFS_CTRL_MODE_W-1:0] mode_out,
  output      logic [15:0]          cfg_active,
  output      logic [15:0]          key_out,
  output      logic                 func_busy,
  output      logic                 soft_rst_pulse
);
  import prfs_pkg::*;

  localparam int FUNC_CYC = (`PRFS_FUNC_NS + `PRFS_CLK_NS - 1) / `PRFS_CLK_NS;

  // ===================================================================
  // request decode
  function automatic logic hit(input prfs_addr_t a, input prfs_addr_t idx);
    hit = (a == idx);
  endfunction

  logic rd_stat, rd_evt;
  logic wr_ctrl, wr_evt, wr_scr, wr_cfg, wr_key;

  always_comb begin
    rd_stat = mgmt_req.rd && hit(mgmt_req.addr, `PRFS_IDX_STAT);
    rd_evt  = mgmt_req.rd && hit(mgmt_req.addr, `PRFS_IDX_EVT);
    wr_ctrl = mgmt_req.wr && hit(mgmt_req.addr, `PRFS_IDX_CTRL);
    wr_evt  = mgmt_req.wr && hit(mgmt_req.addr, `PRFS_IDX_EVT);
    wr_scr  = mgmt_req.wr && hit(mgmt_req.addr, `PRFS_IDX_SCRATCH);
    wr_cfg  = mgmt_req.wr && hit(mgmt_req.addr, `PRFS_IDX_CFG);
    wr_key  = mgmt_req.wr && hit(mgmt_req.addr, `PRFS_IDX_KEY);
  end

  // ===================================================================
  // self-clearing function timer
  logic start_ff, nxt_start;
  logic t_busy, t_done;

  prfs_sc_timer #(
    .RUN_CYC (FUNC_CYC)
  ) u_timer (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .start   (start_ff),
    .busy    (t_busy),
    .done    (t_done)
  );

  // ===================================================================
  // field state
  logic [`PRFS_CTRL_MODE_W-1:0] mode_ff, nxt_mode;
  logic        go_ff, nxt_go;
  logic        srst_ff, nxt_srst;
  logic        lh_ff, nxt_lh;
  logic        ll_ff, nxt_ll;
  logic [ACT_W-1:0] act_ff, nxt_act;
  logic [15:0] scr_ff, nxt_scr;
  logic [15:0] evt_ff, nxt_evt;
  logic [15:0] cfg_ff, nxt_cfg;
  logic [15:0] cfgact_ff, nxt_cfgact;
  logic [15:0] key_ff, nxt_key;
  prfs_rsp_s   rsp_ff, nxt_rsp;

  always_comb begin
    nxt_mode   = mode_ff;
    nxt_go     = go_ff;
    nxt_srst   = 1'b0;
    nxt_start  = 1'b0;
    nxt_lh     = lh_ff;
    nxt_ll     = ll_ff;
    nxt_act    = act_ff;
    nxt_scr    = scr_ff;
    nxt_evt    = evt_ff;
    nxt_cfg    = cfg_ff;
    nxt_cfgact = cfgact_ff;
    nxt_key    = key_ff;
    nxt_rsp    = '0;

    // read data is sampled before any read side effect lands
    if (mgmt_req.rd) begin
      nxt_rsp.valid = 1'b1;
      unique case (mgmt_req.addr)
        `PRFS_IDX_CTRL: begin
          nxt_rsp.rdata[`PRFS_CTRL_RST_BIT]   = srst_ff;
          nxt_rsp.rdata[`PRFS_CTRL_START_BIT] = go_ff;
          nxt_rsp.rdata[`PRFS_CTRL_MODE_W-1:0] = mode_ff;
        end
        `PRFS_IDX_STAT: begin
          nxt_rsp.rdata[`PRFS_STAT_LH_BIT]   = lh_ff;
          nxt_rsp.rdata[`PRFS_STAT_LL_BIT]   = ll_ff;
          nxt_rsp.rdata[`PRFS_STAT_BUSY_BIT] = t_busy;
          nxt_rsp.rdata[`PRFS_STAT_ACT_LSB +: ACT_W] = act_ff;
        end
        `PRFS_IDX_EVT:     nxt_rsp.rdata = evt_ff;
        `PRFS_IDX_SCRATCH: nxt_rsp.rdata = scr_ff;
        `PRFS_IDX_CFG:     nxt_rsp.rdata = cfg_ff;
        // write-only key reads as zero; the manager must not use it
        default:           nxt_rsp.rdata = `PRFS_ZERO16;
      endcase
    end

    // latching status: a read rearms, the live condition wins over it
    if (rd_stat) begin
      nxt_lh  = 1'b0;
      nxt_ll  = 1'b1;
      nxt_act = '0;
    end
    if (cond_high) nxt_lh = 1'b1;
    if (!cond_low) nxt_ll = 1'b0;
    // read-clear counter; an event in the read cycle is kept
    if (evt_pulse) begin
      nxt_act = (rd_stat ? '0 : act_ff) + ACT_W'(1);
    end

    // rw clear-on-read event field
    if (rd_evt) nxt_evt = `PRFS_ZERO16;
    if (wr_evt) nxt_evt = mgmt_req.wdata;

    // control: mode acts at once, start and reset self-clear
    if (wr_ctrl) begin
      nxt_mode = mgmt_req.wdata[`PRFS_CTRL_MODE_W-1:0];
      if (mgmt_req.wdata[`PRFS_CTRL_START_BIT] && !go_ff) begin
        nxt_go    = 1'b1;
        nxt_start = 1'b1;
      end
      nxt_srst = mgmt_req.wdata[`PRFS_CTRL_RST_BIT];
    end
    if (t_done) nxt_go = 1'b0;

    if (wr_scr) nxt_scr = mgmt_req.wdata;
    if (wr_cfg) nxt_cfg = mgmt_req.wdata;
    if (wr_key) nxt_key = mgmt_req.wdata;

    // software reset: deferred config takes effect, scratch, event and mode restart
    if (srst_ff) begin
      nxt_cfgact = cfg_ff;
      nxt_scr    = `PRFS_ZERO16;
      nxt_evt    = `PRFS_ZERO16;
      nxt_mode   = `PRFS_CTRL_MODE_RST;
    end
    // status and unused indices have no write path, so writes there drop
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_ff   <= `PRFS_CTRL_MODE_RST;
      go_ff     <= 1'b0;
      srst_ff   <= 1'b0;
      start_ff  <= 1'b0;
      lh_ff     <= 1'b0;
      ll_ff     <= 1'b1;
      act_ff    <= '0;
      scr_ff    <= `PRFS_ZERO16;
      evt_ff    <= `PRFS_ZERO16;
      cfg_ff    <= `PRFS_CFG_RST;
      cfgact_ff <= `PRFS_CFG_RST;
      key_ff    <= `PRFS_ZERO16;
      rsp_ff    <= '0;
    end else begin
      mode_ff   <= nxt_mode;
      go_ff     <= nxt_go;
      srst_ff   <= nxt_srst;
      start_ff  <= nxt_start;
      lh_ff     <= nxt_lh;
      ll_ff     <= nxt_ll;
      act_ff    <= nxt_act;
      scr_ff    <= nxt_scr;
      evt_ff    <= nxt_evt;
      cfg_ff    <= nxt_cfg;
      cfgact_ff <= nxt_cfgact;
      key_ff    <= nxt_key;
      rsp_ff    <= nxt_rsp;
    end
  end

  // ===================================================================
  // outputs, all registered
  logic busy_ff;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_go;
    end
  end

  assign mgmt_rsp       = rsp_ff;
  assign mode_out       = mode_ff;
  assign cfg_active     = cfgact_ff;
  assign key_out        = key_ff;
  assign func_busy      = busy_ff;
  assign soft_rst_pulse = srst_ff;
endmodule

// ==== test/prfs_mgmt_model.sv ====
// station management controller model issuing one-cycle bank requests
// assumes: bank takes requests on rising sys_clk, answers reads one cycle later
`timescale 1ns/1ps
module prfs_mgmt_model (
  // clock
  input  wire logic                sys_clk,
  // management access
  output      prfs_pkg::prfs_req_s mgmt_req,
  input  wire prfs_pkg::prfs_rsp_s mgmt_rsp
);
  import prfs_pkg::*;
  initial mgmt_req = '0;
  // ============
  // bus cycles
  // released lines show inverted values so a stale request never looks live
  task automatic wr(input prfs_addr_t a, input prfs_word_t d);
    @(negedge sys_clk);
    mgmt_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge sys_clk);
    mgmt_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // callers never compare what a write-only field returns
  task automatic rd(input prfs_addr_t a, output prfs_word_t d);
    @(negedge sys_clk);
    mgmt_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(negedge sys_clk);
    d = mgmt_rsp.valid ? mgmt_rsp.rdata : 16'hXXXX;
    mgmt_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 16'hFFFF};
  endtask
endmodule

// ==== test/prfs_bank_sva.sv ====
// checker for the field-semantics bank
// assumes: one clock domain, requests last one cycle
`timescale 1ns/1ps
`include "prfs_regs.svh"
module prfs_bank_sva #(
  parameter int ACT_W = 8
) (
  // clock and reset
  input wire logic                         sys_clk,
  input wire logic                         rst_b,
  // management access
  input wire prfs_pkg::prfs_req_s          mgmt_req,
  input wire prfs_pkg::prfs_rsp_s          mgmt_rsp,
  // core side
  input wire logic                         cond_high,
  input wire logic                         cond_low,
  input wire logic                         evt_pulse,
  input wire logic [`PRFS_CTRL_MODE_W-1:0] mode_out,
  input wire logic [15:0]                  cfg_active,
  input wire logic [15:0]                  key_out,
  input wire logic                         func_busy,
  input wire logic                         soft_rst_pulse
);
  import prfs_pkg::*;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  logic       rd_stat;
  logic       wr_ctrl;
  logic [3:0] wmode;
  assign rd_stat = mgmt_req.rd && mgmt_req.addr == `PRFS_IDX_STAT;
  assign wr_ctrl = mgmt_req.wr && mgmt_req.addr == `PRFS_IDX_CTRL;
  assign wmode = mgmt_req.wdata[3:0];
  // ============
  // assertions
  AST_RD_ANSWER: assert property (mgmt_req.rd |=> mgmt_rsp.valid)
    else $error("read not answered");
  AST_NO_SPUR: assert property (!mgmt_req.rd |=> !mgmt_rsp.valid)
    else $error("answer without read");
  AST_LH: assert property (cond_high ##1 rd_stat |=> mgmt_rsp.rdata[0])
    else $error("latching high lost");
  AST_LL: assert property (!cond_low ##1 rd_stat |=> !mgmt_rsp.rdata[1])
    else $error("latching low lost");
  AST_RSVD: assert property (rd_stat |=> mgmt_rsp.rdata[15:12] == 4'h0)
    else $error("reserved bits nonzero");
  AST_MODE: assert property (wr_ctrl && !soft_rst_pulse && !mgmt_req.wdata[15]
    |=> mode_out == $past(wmode))
    else $error("mode not applied");
  AST_KEY: assert property (mgmt_req.wr && mgmt_req.addr == `PRFS_IDX_KEY
    |=> key_out == $past(mgmt_req.wdata))
    else $error("key not applied");
  AST_DEFER: assert property (mgmt_req.wr && mgmt_req.addr == `PRFS_IDX_CFG
    && !soft_rst_pulse |=> $stable(cfg_active))
    else $error("config applied early");
  AST_SRST: assert property (wr_ctrl && mgmt_req.wdata[15]
    |=> soft_rst_pulse ##1 (!soft_rst_pulse && mode_out == 4'h0))
    else $error("soft reset pulse wrong");
  AST_SC_GO: assert property (wr_ctrl && mgmt_req.wdata[14] && !mgmt_req.wdata[15]
    && !func_busy |=> ##1 func_busy)
    else $error("start did not run");
  // busy spans the ten run cycles plus the start and done cycles around them
  AST_SC_END: assert property ($rose(func_busy)
    |-> func_busy[*8] ##1 func_busy[*4] ##1 !func_busy)
    else $error("busy length wrong");
  COV_STAT: cover property (rd_stat);
  COV_BUSY: cover property ($rose(func_busy));
  COV_SRST: cover property (soft_rst_pulse);
endmodule

bind prfs_bank prfs_bank_sva #(.ACT_W(ACT_W)) prfs_bank_sva_i (
  .sys_clk        (sys_clk),
  .rst_b          (rst_b),
  .mgmt_req       (mgmt_req),
  .mgmt_rsp       (mgmt_rsp),
  .cond_high      (cond_high),
  .cond_low       (cond_low),
  .evt_pulse      (evt_pulse),
  .mode_out       (mode_out),
  .cfg_active     (cfg_active),
  .key_out        (key_out),
  .func_busy      (func_busy),
  .soft_rst_pulse (soft_rst_pulse)
);

// ==== test/prfs_bank_tb_top.sv ====
// self-checking bench for the field-semantics bank
// assumes: controller model drives requests; bench drives core conditions
`timescale 1ns/1ps
`include "prfs_regs.svh"
module prfs_bank_tb_top;
  import prfs_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       cond_high = 1'b0;
  logic       cond_low = 1'b1;
  logic       evt_pulse = 1'b0;
  prfs_req_s  mgmt_req;
  prfs_rsp_s  mgmt_rsp;
  logic [3:0] mode_out;
  logic [15:0] cfg_active;
  logic [15:0] key_out;
  logic       func_busy;
  logic       soft_rst_pulse;
  int         error_cnt = 0;
  int         checks = 0;
  prfs_word_t v;
  prfs_bank prfs_bank_i (
    .sys_clk        (sys_clk),
    .rst_b          (rst_b),
    .mgmt_req       (mgmt_req),
    .mgmt_rsp       (mgmt_rsp),
    .cond_high      (cond_high),
    .cond_low       (cond_low),
    .evt_pulse      (evt_pulse),
    .mode_out       (mode_out),
    .cfg_active     (cfg_active),
    .key_out        (key_out),
    .func_busy      (func_busy),
    .soft_rst_pulse (soft_rst_pulse)
  );
  prfs_mgmt_model prfs_mgmt_model_i (.sys_clk(sys_clk), .mgmt_req(mgmt_req),
    .mgmt_rsp(mgmt_rsp));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // ============
  // helpers
  task automatic chk(input string n, input prfs_word_t e, input prfs_word_t g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input string n, input prfs_addr_t a, input prfs_word_t e);
    prfs_mgmt_model_i.rd(a, v);
    chk(n, e, v);
  endtask
  task automatic wr(input prfs_addr_t a, input prfs_word_t d);
    prfs_mgmt_model_i.wr(a, d);
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ============
  // scenarios
  task automatic t_reset();
    rst_b = 1'b0;
    repeat (20) @(negedge sys_clk);
    rst_b = 1'b1;
    chk("cfg_active", 16'h1E00, cfg_active);
    chk("key_out", 16'h0000, key_out);
    chk("mode_out", 16'h0000, {12'h000, mode_out});
    chk("func_busy", 16'h0000, {15'h0000, func_busy});
    chk("soft_rst_pulse", 16'h0000, {15'h0000, soft_rst_pulse});
    rdc("cfg", `PRFS_IDX_CFG, 16'h1E00);
    rdc("scratch", `PRFS_IDX_SCRATCH, 16'h0000);
    rdc("evt", `PRFS_IDX_EVT, 16'h0000);
  endtask
  task automatic t_latch();
    prfs_mgmt_model_i.rd(`PRFS_IDX_STAT, v);
    rdc("stat idle", `PRFS_IDX_STAT, 16'h0002);
    // the read lands in the cycle right after the one-cycle condition pulse
    cond_high = 1'b1;
    cond_low = 1'b0;
    fork
      rdc("stat held", `PRFS_IDX_STAT, 16'h0001);
      begin
        @(negedge sys_clk);
        cond_high = 1'b0;
        cond_low = 1'b1;
      end
    join
    rdc("stat reread", `PRFS_IDX_STAT, 16'h0002);
  endtask
  task automatic t_count();
    repeat (3) begin
      @(negedge sys_clk);
      evt_pulse = 1'b1;
      @(negedge sys_clk);
      evt_pulse = 1'b0;
    end
    wr(`PRFS_IDX_STAT, 16'hFFFF);
    rdc("stat count", `PRFS_IDX_STAT, 16'h0032);
    rdc("stat cleared", `PRFS_IDX_STAT, 16'h0002);
  endtask
  task automatic t_rw();
    wr(`PRFS_IDX_SCRATCH, 16'hA5A5);
    rdc("scratch", `PRFS_IDX_SCRATCH, 16'hA5A5);
    wr(`PRFS_IDX_EVT, 16'h1234);
    rdc("evt", `PRFS_IDX_EVT, 16'h1234);
    rdc("evt reread", `PRFS_IDX_EVT, 16'h0000);
    wr(`PRFS_IDX_KEY, 16'h55AA);
    chk("key_out", 16'h55AA, key_out);
    wr(`PRFS_IDX_CTRL, 16'h0005);
    chk("mode_out", 16'h0005, {12'h000, mode_out});
    wr(`PRFS_IDX_CFG, 16'h0042);
    chk("cfg_active", 16'h1E00, cfg_active);
    rdc("cfg", `PRFS_IDX_CFG, 16'h0042);
    wr(`PRFS_IDX_CTRL, 16'h8000);
    chk("soft_rst_pulse", 16'h0001, {15'h0000, soft_rst_pulse});
    repeat (2) @(negedge sys_clk);
    chk("soft_rst_pulse", 16'h0000, {15'h0000, soft_rst_pulse});
    chk("cfg_active", 16'h0042, cfg_active);
    chk("mode_out", 16'h0000, {12'h000, mode_out});
    rdc("scratch", `PRFS_IDX_SCRATCH, 16'h0000);
    rdc("ctrl", `PRFS_IDX_CTRL, 16'h0000);
  endtask
  task automatic t_sc();
    int n;
    wr(`PRFS_IDX_CTRL, 16'h4000);
    chk("func_busy", 16'h0001, {15'h0000, func_busy});
    // busy covers the run plus the start and done cycles around it
    n = 0;
    while (func_busy === 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    chk("busy cycles", 16'(`PRFS_FUNC_NS / `PRFS_CLK_NS + 2), 16'(n));
    rdc("ctrl idle", `PRFS_IDX_CTRL, 16'h0000);
    wr(`PRFS_IDX_CTRL, 16'h4000);
    rdc("ctrl running", `PRFS_IDX_CTRL, 16'h4000);
    rdc("stat busy", `PRFS_IDX_STAT, 16'h0006);
    n = 0;
    while (func_busy !== 1'b0 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    rdc("ctrl done", `PRFS_IDX_CTRL, 16'h0000);
  endtask
  // mid-run hardware reset once scratch, event, mode, config and key are off their defaults
  task automatic t_hw_reset();
    wr(`PRFS_IDX_SCRATCH, 16'h00C3);
    wr(`PRFS_IDX_EVT, 16'h003C);
    wr(`PRFS_IDX_CTRL, 16'h0007);
    chk("mode_out", 16'h0007, {12'h000, mode_out});
    t_reset();
  endtask
  initial begin
    t_reset();
    t_latch();
    t_count();
    t_rw();
    t_sc();
    t_hw_reset();
    report_and_stop();
  end
  initial begin
    #20000;
    error_cnt++;
    report_and_stop();
  end
endmodule
